/* design/node_state_pkg.sv */
// Package for the node state machine: register offsets, state codes,
// error reason codes and the carrier structs shared by the design.
// Assumes a 16-bit register port inside the node controller.
package node_state_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [ADDR_W-1:0] STATE_REQUEST_OFS = 12'h120;
	localparam logic [ADDR_W-1:0] STATE_REPORT_OFS = 12'h130;
	localparam logic [ADDR_W-1:0] STATE_ERROR_REASON_OFS = 12'h134;

	// Field layout of request and report registers
	localparam int STATE_LSB = 0;
	localparam int STATE_W = 4;
	localparam int ACK_BIT = 4;
	localparam int ERR_BIT = 4;

	// Reset values
	localparam logic [DATA_W-1:0] STATE_REQUEST_RST = 16'h0001;
	localparam logic [DATA_W-1:0] ERROR_REASON_RST = 16'h0000;

	// Error reason codes
	localparam logic [DATA_W-1:0] ERR_NONE = 16'h0000;
	localparam logic [DATA_W-1:0] ERR_BAD_REQUEST = 16'h0011;
	localparam logic [DATA_W-1:0] ERR_BAD_TRANSITION = 16'h0012;
	localparam logic [DATA_W-1:0] ERR_BAD_CONFIG = 16'h0016;
	localparam logic [DATA_W-1:0] ERR_CONFIG_LOST = 16'h001a;

	typedef enum logic [3:0] {
		INIT_STATE = 4'h1,
		PRE_RUN_STATE = 4'h2,
		BOOT_STATE = 4'h3,
		INPUTS_ONLY_STATE = 4'h4,
		FULL_RUN_STATE = 4'h8
	} node_state_t;

	// Register access from the network side
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// Service permissions derived from the current state
	typedef struct packed {
		logic app_layer;
		logic mailbox;
		logic boot_mailbox;
		logic inputs;
		logic outputs;
	} service_t;

endpackage

/* design/node_state_machine.sv */
// Node state machine: request/report/reason registers and service gates.
// Assumes the register port and validation inputs are on CLK_I already;
// the local application controller answers each validation request.
`timescale 1ns/1ns
module node_state_machine
	import node_state_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire reg_req_t REG_REQ_I,
	output logic [DATA_W-1:0] REG_RDATA_O,
	output logic VALIDATE_REQ_O,
	output node_state_t VALIDATE_STATE_O,
	input wire logic VALIDATE_DONE_I,
	input wire logic VALIDATE_OK_I,
	input wire logic [DATA_W-1:0] VALIDATE_CODE_I,
	input wire logic CONFIG_FAULT_I,
	output service_t SERVICE_O
);

	typedef enum logic [1:0] {
		IDLE_PH = 2'b00,
		CHECK_PH = 2'b01
	} phase_t;

	node_state_t state_q, state_d;
	node_state_t target_q, target_d;
	phase_t phase_q, phase_d;
	logic [DATA_W-1:0] request_q, request_d;
	logic [DATA_W-1:0] reason_q, reason_d;
	logic err_q, err_d;
	logic pend_q, pend_d;

	// Legal state code check
	function automatic logic legal_code(input logic [STATE_W-1:0] c);
		return c == INIT_STATE || c == PRE_RUN_STATE || c == BOOT_STATE ||
			c == INPUTS_ONLY_STATE || c == FULL_RUN_STATE;
	endfunction

	// Upward steps go one level at a time; boot only to and from init
	function automatic logic legal_step(input node_state_t f,
		input node_state_t t);
		logic ok;
		ok = 1'b0;
		if (t == INIT_STATE || t == f)
			ok = 1'b1;
		else if (t == BOOT_STATE)
			ok = (f == INIT_STATE);
		else if (f == BOOT_STATE)
			ok = 1'b0;
		else if (t == PRE_RUN_STATE)
			ok = 1'b1;
		else if (t == INPUTS_ONLY_STATE)
			ok = (f != INIT_STATE);
		else if (t == FULL_RUN_STATE)
			ok = (f == INPUTS_ONLY_STATE || f == FULL_RUN_STATE);
		return ok;
	endfunction

	wire logic req_wr = REG_REQ_I.wr && REG_REQ_I.addr == STATE_REQUEST_OFS;

	// Next state of the node state machine and its registers
	always_comb
	begin
		state_d = state_q;
		target_d = target_q;
		phase_d = phase_q;
		request_d = request_q;
		reason_d = reason_q;
		err_d = err_q;
		pend_d = pend_q;
		if (req_wr)
		begin
			request_d = REG_REQ_I.wdata;
			pend_d = 1'b1;
			if (REG_REQ_I.wdata[ACK_BIT])
				err_d = 1'b0;
		end
		unique case (phase_q)
			IDLE_PH:
				if (pend_q && !req_wr)
				begin
					pend_d = 1'b0;
					if (!legal_code(request_q[STATE_LSB +: STATE_W]))
					begin
						err_d = 1'b1;
						reason_d = ERR_BAD_REQUEST;
					end
					else if (!legal_step(state_q,
						node_state_t'(request_q[STATE_LSB +: STATE_W])))
					begin
						err_d = 1'b1;
						reason_d = ERR_BAD_TRANSITION;
					end
					else if (request_q[STATE_LSB +: STATE_W] == state_q)
						state_d = state_q;
					else
					begin
						target_d =
							node_state_t'(request_q[STATE_LSB +: STATE_W]);
						phase_d = CHECK_PH;
					end
				end
			CHECK_PH:
				if (VALIDATE_DONE_I)
				begin
					phase_d = IDLE_PH;
					if (VALIDATE_OK_I)
					begin
						state_d = target_q;
						reason_d = ERR_NONE;
					end
					else
					begin
						err_d = 1'b1;
						reason_d = VALIDATE_CODE_I;
					end
				end
			default: phase_d = IDLE_PH;
		endcase
		// Configuration faults outside init and boot win over any confirmation
		if (CONFIG_FAULT_I && state_q != INIT_STATE &&
			state_q != BOOT_STATE)
		begin
			state_d = (state_q == PRE_RUN_STATE) ? INIT_STATE :
				PRE_RUN_STATE;
			phase_d = IDLE_PH;
			err_d = 1'b1;
			reason_d = ERR_CONFIG_LOST;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state_q <= INIT_STATE;
			target_q <= INIT_STATE;
			phase_q <= IDLE_PH;
			request_q <= STATE_REQUEST_RST;
			reason_q <= ERROR_REASON_RST;
			err_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			target_q <= target_d;
			phase_q <= phase_d;
			request_q <= request_d;
			reason_q <= reason_d;
			err_q <= err_d;
			pend_q <= pend_d;
		end
	end

	// Read data registered; unmapped offsets read zero
	logic [DATA_W-1:0] rdata_d, rdata_q;
	always_comb
	begin
		rdata_d = '0;
		if (REG_REQ_I.rd)
		begin
			unique case (REG_REQ_I.addr)
				STATE_REQUEST_OFS: rdata_d = request_q;
				STATE_REPORT_OFS:
				begin
					rdata_d[STATE_LSB +: STATE_W] = state_q;
					rdata_d[ERR_BIT] = err_q;
				end
				STATE_ERROR_REASON_OFS: rdata_d = reason_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end

	assign REG_RDATA_O = rdata_q;
	assign VALIDATE_REQ_O = (phase_q == CHECK_PH);
	assign VALIDATE_STATE_O = target_q;

	// Service gates per state
	always_comb
	begin
		SERVICE_O = '0;
		unique case (state_q)
			PRE_RUN_STATE: SERVICE_O.mailbox = 1'b1;
			BOOT_STATE:
			begin
				SERVICE_O.mailbox = 1'b1;
				SERVICE_O.boot_mailbox = 1'b1;
			end
			INPUTS_ONLY_STATE:
			begin
				SERVICE_O.mailbox = 1'b1;
				SERVICE_O.inputs = 1'b1;
			end
			FULL_RUN_STATE:
			begin
				SERVICE_O.mailbox = 1'b1;
				SERVICE_O.inputs = 1'b1;
				SERVICE_O.outputs = 1'b1;
			end
			default: SERVICE_O = '0;
		endcase
		SERVICE_O.app_layer = SERVICE_O.mailbox;
	end

	// Checks
	a_confirm_needs_ok: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) (state_q != $past(state_q) &&
		!$past(CONFIG_FAULT_I)) |-> $past(VALIDATE_DONE_I &&
		VALIDATE_OK_I && phase_q == CHECK_PH))
		else $error("state changed without validation");
	a_confirm_target: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) (phase_q == CHECK_PH &&
		VALIDATE_DONE_I && VALIDATE_OK_I && !CONFIG_FAULT_I) |=>
		state_q == $past(target_q))
		else $error("confirmed state differs from target");
	a_reject_flags: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) (phase_q == CHECK_PH &&
		VALIDATE_DONE_I && !VALIDATE_OK_I && !CONFIG_FAULT_I) |=>
		err_q && reason_q == $past(VALIDATE_CODE_I))
		else $error("rejection not reported");
	a_init_quiet: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I)
		state_q == INIT_STATE |-> SERVICE_O == '0)
		else $error("services open in init");
	a_prerun_nodata: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) state_q == PRE_RUN_STATE |->
		SERVICE_O.mailbox && !SERVICE_O.inputs && !SERVICE_O.outputs)
		else $error("pre-run services wrong");
	a_safe_outputs: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) state_q == INPUTS_ONLY_STATE |->
		SERVICE_O.mailbox && SERVICE_O.inputs && !SERVICE_O.outputs)
		else $error("outputs live in inputs-only");
	a_full_run: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) state_q == FULL_RUN_STATE |->
		SERVICE_O.inputs && SERVICE_O.outputs)
		else $error("full run lacks data");
	a_boot_mailbox: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I) state_q == BOOT_STATE |->
		SERVICE_O.boot_mailbox && SERVICE_O.mailbox &&
		!SERVICE_O.inputs && !SERVICE_O.outputs)
		else $error("boot services wrong");
	a_fault_drop: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I)
		(CONFIG_FAULT_I && state_q == FULL_RUN_STATE) |=>
		state_q == PRE_RUN_STATE && err_q)
		else $error("fault did not lower state");
	a_err_sticky: assert property (@(posedge CLK_I)
		disable iff (!RST_N_I)
		(err_q && !(req_wr && REG_REQ_I.wdata[ACK_BIT])) |=> err_q)
		else $error("error flag dropped without ack");

	c_to_full_run: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == FULL_RUN_STATE);
	c_rejected: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		$rose(err_q) && reason_q != ERR_CONFIG_LOST);
	c_boot: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		state_q == BOOT_STATE);
	c_fault: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		CONFIG_FAULT_I && state_q == INPUTS_ONLY_STATE);

endmodule

/* dv/app_validator.sv */
// Model of the local application controller that judges each request.
// Assumes the validation handshake of the node state machine on one clock.
`timescale 1ns/1ns
module app_validator
	import node_state_pkg::*;
#(
	parameter int DELAY = 6
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic ok_i,
	input wire logic [DATA_W-1:0] code_i,
	output logic done_o,
	output logic ok_o,
	output logic [DATA_W-1:0] code_o
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic done_q;
	logic done_d;

	// Verdict only after a real delay, never in the request cycle
	always_comb
	begin
		cnt_d = (req_i && !done_q) ? cnt_q + 8'h01 : 8'h00;
		done_d = req_i && !done_q && (cnt_q == 8'(DELAY - 1));
	end

	// Registers of the answer timer
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 8'h00;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	// Outside the pulse the verdict lines carry junk, not the last value
	assign done_o = done_q;
	assign ok_o = done_q ? ok_i : ~ok_i;
	assign code_o = done_q ? code_i : ~code_i;
endmodule

/* dv/node_state_machine_tb.sv */
// Self-checking bench for the node state machine.
// Assumes the validator model answers every validation request.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	err_total++; $display("Error %s exp %h got %h", nm, e, g); end end
module node_state_machine_tb;
	import node_state_pkg::*;
	logic clk, rst_n, vreq, vdone, vok, v_ok, fault;
	logic [DATA_W-1:0] rdata, vcode, v_code;
	reg_req_t req;
	node_state_t vstate;
	service_t svc;
	int err_total = 0;
	int n_compared = 0;

	node_state_machine dut_u (.CLK_I(clk), .RST_N_I(rst_n),
		.REG_REQ_I(req), .REG_RDATA_O(rdata), .VALIDATE_REQ_O(vreq),
		.VALIDATE_STATE_O(vstate), .VALIDATE_DONE_I(vdone),
		.VALIDATE_OK_I(vok), .VALIDATE_CODE_I(vcode),
		.CONFIG_FAULT_I(fault), .SERVICE_O(svc));
	app_validator #(.DELAY(6)) val_u (.clk_i(clk), .rst_n_i(rst_n),
		.req_i(vreq), .ok_i(v_ok), .code_i(v_code), .done_o(vdone),
		.ok_o(vok), .code_o(vcode));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic test_done;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req <= '0;
		#1 `CHK($sformatf("reg %h", a), e, rdata)
	endtask

	// Bounded wait for the validation handshake to finish
	// Sampled just after the edge, so the launched value has settled
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
		for (int i = 0; i < 50 && vreq !== 1'b0; i++)
			@(posedge clk) #1;
		`CHK("vreq idle", 1'b0, vreq)
	endtask

	task automatic go(input logic [15:0] d, input logic ok,
		input logic [15:0] rpt);
		@(posedge clk);
		v_ok <= ok;
		wr(STATE_REQUEST_OFS, d);
		settle();
		rd(STATE_REPORT_OFS, rpt);
	endtask

	// Watchdog: whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		test_done();
	end

	initial
	begin
		rst_n = 1'b0;
		req = '0;
		fault = 1'b0;
		v_ok = 1'b1;
		v_code = 16'h0016;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(STATE_REQUEST_OFS, STATE_REQUEST_RST);
		rd(STATE_REPORT_OFS, 16'h0001);
		rd(STATE_ERROR_REASON_OFS, ERROR_REASON_RST);
		`CHK("svc", 5'h00, svc)
		// Link, mailbox and clock sync setup sit outside
		// Expected reports are the master's copy of this node
		// Report must not move while the verdict is pending
		wr(STATE_REQUEST_OFS, 16'h0002);
		rd(STATE_REPORT_OFS, 16'h0001);
		`CHK("vstate", PRE_RUN_STATE, vstate)
		settle();
		rd(STATE_REPORT_OFS, 16'h0002);
		`CHK("svc pre", 5'b11000, svc)
		go(16'h0004, 1'b1, 16'h0004);
		`CHK("svc in", 5'b11010, svc)
		go(16'h0008, 1'b1, 16'h0008);
		`CHK("svc full", 5'b11011, svc)
		go(16'h0004, 1'b0, 16'h0018);
		rd(STATE_ERROR_REASON_OFS, 16'h0016);
		go(16'h0018, 1'b1, 16'h0008);
		go(16'h0005, 1'b1, 16'h0018);
		rd(STATE_ERROR_REASON_OFS, ERR_BAD_REQUEST);
		go(16'h0018, 1'b1, 16'h0008);
		// Controller register fault drops full run back to pre-run
		@(posedge clk);
		fault <= 1'b1;
		@(posedge clk);
		fault <= 1'b0;
		rd(STATE_REPORT_OFS, 16'h0012);
		rd(STATE_ERROR_REASON_OFS, ERR_CONFIG_LOST);
		go(16'h0011, 1'b1, 16'h0001);
		`CHK("svc init", 5'h00, svc)
		wr(STATE_REPORT_OFS, 16'h0008);
		rd(STATE_REPORT_OFS, 16'h0001);
		rd(12'h200, 16'h0000);
		go(16'h0003, 1'b1, 16'h0003);
		`CHK("svc boot", 5'b11100, svc)
		go(16'h0004, 1'b1, 16'h0013);
		rd(STATE_ERROR_REASON_OFS, ERR_BAD_TRANSITION);
		test_done();
	end
endmodule
